//--- common/lpd_pkg.sv
package lpd_pkg;

	// Command-phase opcodes.
	localparam logic [7:0] LPD_CMD_OSC_FAST   = 8'hE4;
	localparam logic [7:0] LPD_CMD_OSC_SLOW   = 8'hE5;
	localparam logic [7:0] LPD_CMD_MODE_NORM  = 8'h82;
	localparam logic [7:0] LPD_CMD_MODE_PART  = 8'h83;
	localparam logic [7:0] LPD_CMD_NINV_OFF   = 8'h84;
	localparam logic [7:0] LPD_CMD_NINV_SET   = 8'h85;
	localparam logic [7:0] LPD_CMD_START_SET  = 8'hD3;
	localparam logic [7:0] LPD_CMD_PUMP_SET   = 8'hE6;
	localparam logic [7:0] LPD_CMD_RESET      = 8'hE2;
	localparam logic [7:0] LPD_CMD_DUTY_FIRST = 8'h30;
	localparam logic [7:0] LPD_CMD_DUTY_LAST  = 8'h34;
	localparam logic [7:0] LPD_CMD_BIAS_FIRST = 8'h38;
	localparam logic [7:0] LPD_CMD_BIAS_LAST  = 8'h3D;
	localparam logic [7:0] LPD_CMD_TEST_FIRST = 8'hF0;

	// Field widths of the value bytes.
	localparam int LPD_START_W = 6;
	localparam int LPD_NINV_W  = 5;
	localparam int LPD_DIV_W   = 4;
	localparam int LPD_CODE_W  = 3;
	localparam int LPD_LINES_W = 7;

	// Partial duty codes, low three bits of 30h..34h.
	localparam logic [2:0] LPD_DUTY_9  = 3'h0;
	localparam logic [2:0] LPD_DUTY_17 = 3'h1;
	localparam logic [2:0] LPD_DUTY_33 = 3'h2;
	localparam logic [2:0] LPD_DUTY_49 = 3'h3;
	localparam logic [2:0] LPD_DUTY_65 = 3'h4;

	// Reset values.
	localparam logic                   LPD_OSC_SLOW_RST = 1'b0;
	localparam logic [LPD_DIV_W-1:0]   LPD_DIV_RST      = 4'h3;
	localparam logic [2:0]             LPD_PDUTY_RST    = LPD_DUTY_65;
	localparam logic [2:0]             LPD_PBIAS_RST    = 3'h5;
	localparam logic [LPD_START_W-1:0] LPD_START_RST    = 6'h00;
	localparam logic [LPD_NINV_W-1:0]  LPD_NINV_RST     = 5'h00;

	// Effective drive settings handed to the common and bias circuits.
	typedef struct packed {
		logic                   partial;
		logic [2:0]             duty_code;
		logic [2:0]             bias_code;
		logic                   normal_bias;
		logic [LPD_START_W-1:0] start_line;
		logic                   ninv_on;
		logic [LPD_NINV_W-1:0]  ninv_lines;
	} lpd_drive_t;

	// Maximum duty fixed by the two duty-option pins.
	function automatic logic [2:0] lpd_max_duty(input logic hi, input logic lo);
		unique case ({hi, lo})
			2'b00:   lpd_max_duty = LPD_DUTY_33;
			2'b01:   lpd_max_duty = LPD_DUTY_49;
			default: lpd_max_duty = LPD_DUTY_65;
		endcase
	endfunction : lpd_max_duty

	// Scanned lines for a duty code, indicator common not counted.
	function automatic logic [LPD_LINES_W-1:0] lpd_lines_of(input logic [2:0] code);
		unique case (code)
			LPD_DUTY_9:  lpd_lines_of = 7'h08;
			LPD_DUTY_17: lpd_lines_of = 7'h10;
			LPD_DUTY_33: lpd_lines_of = 7'h20;
			LPD_DUTY_49: lpd_lines_of = 7'h30;
			default:     lpd_lines_of = 7'h40;
		endcase
	endfunction : lpd_lines_of

	// Partial bias that goes with each partial duty (0 is 1/4 .. 5 is 1/9).
	function automatic logic [2:0] lpd_bias_for_duty(input logic [2:0] code);
		unique case (code)
			LPD_DUTY_9:  lpd_bias_for_duty = 3'h0;
			LPD_DUTY_17: lpd_bias_for_duty = 3'h1;
			LPD_DUTY_33: lpd_bias_for_duty = 3'h2;
			LPD_DUTY_49: lpd_bias_for_duty = 3'h3;
			default:     lpd_bias_for_duty = 3'h5;
		endcase
	endfunction : lpd_bias_for_duty

endpackage : lpd_pkg

//--- rtl/lpd_limit.sv
`timescale 1ns/10ps
module lpd_limit (
	// Stored settings.
	input  wire logic                           i_part_mode,
	input  wire logic [2:0]                     i_pduty,
	input  wire logic [2:0]                     i_pbias,
	input  wire logic [lpd_pkg::LPD_START_W-1:0] i_pstart,
	input  wire logic                           i_ninv_on,
	input  wire logic [lpd_pkg::LPD_NINV_W-1:0] i_ninv_val,
	// Board straps and normal-mode bias.
	input  wire logic                           i_duty_option_pin_hi,
	input  wire logic                           i_duty_option_pin_lo,
	input  wire logic                           i_normal_bias,
	// Resolved drive settings.
	output lpd_pkg::lpd_drive_t                 o_cfg
);

	logic [2:0] max_duty;

	assign max_duty = lpd_pkg::lpd_max_duty(i_duty_option_pin_hi, i_duty_option_pin_lo);

	// Picks duty, bias, start line and inversion from the current display mode.
	always_comb begin
		o_cfg             = '0;
		o_cfg.partial     = i_part_mode;
		o_cfg.normal_bias = i_normal_bias;
		o_cfg.ninv_lines  = i_ninv_val;
		if (i_part_mode) begin
			o_cfg.duty_code = (i_pduty > max_duty) ? max_duty : i_pduty;
			o_cfg.bias_code = i_pbias;
			if ({1'b0, i_pstart} > lpd_pkg::lpd_lines_of(max_duty)) begin
				o_cfg.start_line = '0;
			end else begin
				o_cfg.start_line = i_pstart;
			end
			o_cfg.ninv_on = i_ninv_on && (o_cfg.duty_code > lpd_pkg::LPD_DUTY_17);
		end else begin
			o_cfg.duty_code = max_duty;
			o_cfg.ninv_on   = i_ninv_on;
		end
	end

endmodule : lpd_limit

//--- rtl/lpd_com_mask.sv
`timescale 1ns/10ps
module lpd_com_mask #(
	parameter int NUM_COM = 65
) (
	// Resolved drive settings.
	input  lpd_pkg::lpd_drive_t       i_cfg,
	// One bit per common, high where the select waveform may appear.
	output logic [NUM_COM-1:0]        o_active
);

	// The indicator common sits on the top bit; 64 scan lines lie below it.
	if (NUM_COM != 65) begin : g_bad_count
		$error("lpd_com_mask: NUM_COM must be 65");
	end

	logic [7:0] first_line;
	logic [7:0] end_line;

	assign first_line = {2'b00, i_cfg.start_line};
	assign end_line   = first_line + {1'b0, lpd_pkg::lpd_lines_of(i_cfg.duty_code)};

	// Commons outside the scanned window, except the indicator common, get the non-select waveform.
	always_comb begin
		o_active = '0;
		for (int i = 0; i < NUM_COM - 1; i++) begin
			o_active[i] = (8'(i) >= first_line) && (8'(i) < end_line);
		end
		o_active[NUM_COM-1] = 1'b1;
	end

endmodule : lpd_com_mask

//--- rtl/lpd_cmd_decoder.sv
`timescale 1ns/10ps
// How it works
// - E4h picks fast oscillator, E5h the slow.
// - 82h: normal mode, duty from pins.
// - 83h: partial mode, partial duty and bias.
// - Partial settings ignored in normal mode.
// - 30h..34h set partial duty; 35h..37h ignored.
// - Duty code also sets its matching bias.
// - Requested duty above pin maximum is clamped.
// - 38h..3Dh set partial bias; 3Eh/3Fh reserved.
// - Commons outside active area get non-select.
// - D3h is followed only by its value byte.
// - Value bits 5..0 load start line.
// - Start line past pin maximum becomes zero.
// - 85h is followed only by its value byte.
// - Value bits 4..0 set inversion line count.
// - Partial duty 1/9 or 1/17 cancels inversion.
// - 84h cancels N-line inversion.
// - E6h is followed only by its value byte.
// - Value bits 3..0 set charge-pump divider.
// - F0h..FFh enter test mode; reset releases.
module lpd_cmd_decoder #(
	parameter int NUM_COM = 65
) (
	// Clock, reset and enable.
	input  wire logic                            i_clk,
	input  wire logic                            i_sys_rst,
	input  wire logic                            i_clk_en,
	// Host byte port.
	input  wire logic                            i_wr_strobe,
	input  wire logic                            i_register_select,
	input  wire logic [7:0]                      i_wr_byte,
	// Straps and normal-mode bias.
	input  wire logic                            i_duty_option_pin_hi,
	input  wire logic                            i_duty_option_pin_lo,
	input  wire logic                            i_normal_bias,
	// Oscillator, charge pump and test state.
	output logic                                 o_osc_slow,
	output logic [lpd_pkg::LPD_DIV_W-1:0]        o_pump_div,
	output logic                                 o_test_mode,
	// Display drive settings.
	output lpd_pkg::lpd_drive_t                  o_drive_cfg,
	output logic [NUM_COM-1:0]                   o_com_active
);

	typedef enum logic [1:0] {ST_IDLE, ST_START_ARG, ST_NINV_ARG, ST_PUMP_ARG} lpd_state_t;

	lpd_state_t                       state_ff;
	logic                             part_mode_ff;
	logic [2:0]                       pduty_ff;
	logic [2:0]                       pbias_ff;
	logic [lpd_pkg::LPD_START_W-1:0]  pstart_ff;
	logic                             ninv_on_ff;
	logic [lpd_pkg::LPD_NINV_W-1:0]   ninv_val_ff;
	logic                             take;
	logic                             take_idle;
	logic                             is_duty;
	logic                             is_bias;
	lpd_pkg::lpd_drive_t              nxt_cfg;
	logic [NUM_COM-1:0]               nxt_active;
	logic [2:0]                       max_duty;

	// Only command-phase writes are decoded; display data bytes pass by.
	assign take      = i_clk_en && i_wr_strobe && !i_register_select;
	assign take_idle = take && (state_ff == ST_IDLE);
	assign is_duty   = (i_wr_byte >= lpd_pkg::LPD_CMD_DUTY_FIRST) &&
	                   (i_wr_byte <= lpd_pkg::LPD_CMD_DUTY_LAST);
	assign is_bias   = (i_wr_byte >= lpd_pkg::LPD_CMD_BIAS_FIRST) &&
	                   (i_wr_byte <= lpd_pkg::LPD_CMD_BIAS_LAST);
	assign max_duty  = lpd_pkg::lpd_max_duty(i_duty_option_pin_hi, i_duty_option_pin_lo);

	// Opcode sequencer: a paired opcode makes the next byte its value.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_ff <= ST_IDLE;
		end else if (take) begin
			unique case (state_ff)
				ST_IDLE: begin
					if (i_wr_byte == lpd_pkg::LPD_CMD_START_SET) begin
						state_ff <= ST_START_ARG;
					end else if (i_wr_byte == lpd_pkg::LPD_CMD_NINV_SET) begin
						state_ff <= ST_NINV_ARG;
					end else if (i_wr_byte == lpd_pkg::LPD_CMD_PUMP_SET) begin
						state_ff <= ST_PUMP_ARG;
					end
				end
				ST_START_ARG, ST_NINV_ARG, ST_PUMP_ARG: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Oscillator speed select.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_osc_slow <= lpd_pkg::LPD_OSC_SLOW_RST;
		end else if (take_idle) begin
			if (i_wr_byte == lpd_pkg::LPD_CMD_OSC_FAST) begin
				o_osc_slow <= 1'b0;
			end else if (i_wr_byte == lpd_pkg::LPD_CMD_OSC_SLOW) begin
				o_osc_slow <= 1'b1;
			end
		end
	end

	// Normal or partial display mode.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			part_mode_ff <= 1'b0;
		end else if (take_idle) begin
			if (i_wr_byte == lpd_pkg::LPD_CMD_MODE_NORM) begin
				part_mode_ff <= 1'b0;
			end else if (i_wr_byte == lpd_pkg::LPD_CMD_MODE_PART) begin
				part_mode_ff <= 1'b1;
			end
		end
	end

	// Partial duty and bias; a duty write carries its own bias along.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pduty_ff <= lpd_pkg::LPD_PDUTY_RST;
			pbias_ff <= lpd_pkg::LPD_PBIAS_RST;
		end else if (take_idle) begin
			if (is_duty) begin
				pduty_ff <= i_wr_byte[2:0];
				pbias_ff <= lpd_pkg::lpd_bias_for_duty(i_wr_byte[2:0]);
			end else if (is_bias) begin
				pbias_ff <= i_wr_byte[2:0];
			end
		end
	end

	// Partial start line, loaded from the value byte after D3h.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pstart_ff <= lpd_pkg::LPD_START_RST;
		end else if (take && (state_ff == ST_START_ARG)) begin
			pstart_ff <= i_wr_byte[lpd_pkg::LPD_START_W-1:0];
		end
	end

	// N-line inversion enable and line count.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ninv_on_ff  <= 1'b0;
			ninv_val_ff <= lpd_pkg::LPD_NINV_RST;
		end else if (take && (state_ff == ST_NINV_ARG)) begin
			ninv_on_ff  <= 1'b1;
			ninv_val_ff <= i_wr_byte[lpd_pkg::LPD_NINV_W-1:0];
		end else if (take_idle && (i_wr_byte == lpd_pkg::LPD_CMD_NINV_OFF)) begin
			ninv_on_ff <= 1'b0;
		end
	end

	// Charge-pump clock divider code.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pump_div <= lpd_pkg::LPD_DIV_RST;
		end else if (take && (state_ff == ST_PUMP_ARG)) begin
			o_pump_div <= i_wr_byte[lpd_pkg::LPD_DIV_W-1:0];
		end
	end

	// Test mode latch; only the reset opcode or a hardware reset clears it.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_test_mode <= 1'b0;
		end else if (take_idle) begin
			if (i_wr_byte >= lpd_pkg::LPD_CMD_TEST_FIRST) begin
				o_test_mode <= 1'b1;
			end else if (i_wr_byte == lpd_pkg::LPD_CMD_RESET) begin
				o_test_mode <= 1'b0;
			end
		end
	end

	lpd_limit u_limit (
		.i_part_mode          (part_mode_ff),
		.i_pduty              (pduty_ff),
		.i_pbias              (pbias_ff),
		.i_pstart             (pstart_ff),
		.i_ninv_on            (ninv_on_ff),
		.i_ninv_val           (ninv_val_ff),
		.i_duty_option_pin_hi (i_duty_option_pin_hi),
		.i_duty_option_pin_lo (i_duty_option_pin_lo),
		.i_normal_bias        (i_normal_bias),
		.o_cfg                (nxt_cfg)
	);

	lpd_com_mask #(
		.NUM_COM (NUM_COM)
	) u_mask (
		.i_cfg    (nxt_cfg),
		.o_active (nxt_active)
	);

	// Registers the resolved drive settings one enabled edge behind the state.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_drive_cfg  <= '0;
			o_com_active <= '0;
		end else if (i_clk_en) begin
			o_drive_cfg  <= nxt_cfg;
			o_com_active <= nxt_active;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	chk_osc_select: assert property (
		take_idle && (i_wr_byte[7:1] == lpd_pkg::LPD_CMD_OSC_FAST[7:1])
		|=> o_osc_slow == $past(i_wr_byte[0]))
		else $error("oscillator select did not follow E4h/E5h");

	chk_normal_duty: assert property (
		i_clk_en && !part_mode_ff
		|=> (o_drive_cfg.duty_code == $past(max_duty)) && !o_drive_cfg.partial)
		else $error("normal mode duty not taken from the option pins");

	chk_partial_enter: assert property (
		take_idle && (i_wr_byte == lpd_pkg::LPD_CMD_MODE_PART)
		|=> part_mode_ff ##0 i_clk_en [*1] |=> o_drive_cfg.partial)
		else $error("partial mode not entered after 83h");

	chk_normal_nobias: assert property (
		i_clk_en && !part_mode_ff |=> o_drive_cfg.bias_code == 3'h0)
		else $error("partial bias leaked into normal mode");

	chk_duty_reserved: assert property (
		take_idle && (i_wr_byte > lpd_pkg::LPD_CMD_DUTY_LAST) &&
		(i_wr_byte < lpd_pkg::LPD_CMD_BIAS_FIRST)
		|=> $stable(pduty_ff) && $stable(pbias_ff))
		else $error("reserved duty code changed a setting");

	chk_duty_bias: assert property (
		take_idle && is_duty
		|=> (pduty_ff == $past(i_wr_byte[2:0])) &&
		(pbias_ff == lpd_pkg::lpd_bias_for_duty(pduty_ff)))
		else $error("duty write did not set duty and matching bias");

	chk_duty_clamp: assert property (
		i_clk_en && part_mode_ff && (pduty_ff > max_duty)
		|=> o_drive_cfg.duty_code == $past(max_duty))
		else $error("partial duty not clamped to the pin maximum");

	chk_bias_set: assert property (
		take_idle && is_bias |=> pbias_ff == $past(i_wr_byte[2:0]))
		else $error("partial bias code not stored");

	chk_com_window: assert property (
		i_clk_en |=> o_com_active[NUM_COM-1] &&
		($countones(o_com_active) <= 1 + lpd_pkg::lpd_lines_of(o_drive_cfg.duty_code)))
		else $error("select waveform outside the active area");

	chk_start_pair: assert property (
		take_idle && (i_wr_byte == lpd_pkg::LPD_CMD_START_SET) |=> state_ff == ST_START_ARG)
		else $error("start line opcode did not wait for its value");

	chk_start_load: assert property (
		take && (state_ff == ST_START_ARG)
		|=> (state_ff == ST_IDLE) && (pstart_ff == $past(i_wr_byte[5:0])))
		else $error("start line value byte not loaded");

	chk_start_zero: assert property (
		i_clk_en && part_mode_ff &&
		({1'b0, pstart_ff} > lpd_pkg::lpd_lines_of(max_duty))
		|=> o_drive_cfg.start_line == '0)
		else $error("out-of-range start line not forced to zero");

	chk_ninv_load: assert property (
		take && (state_ff == ST_NINV_ARG)
		|=> ninv_on_ff && (ninv_val_ff == $past(i_wr_byte[4:0])) && (state_ff == ST_IDLE))
		else $error("inversion value byte not loaded");

	chk_ninv_frame: assert property (
		i_clk_en && part_mode_ff && (pduty_ff <= lpd_pkg::LPD_DUTY_17)
		|=> !o_drive_cfg.ninv_on)
		else $error("inversion active at 1/9 or 1/17 partial duty");

	chk_ninv_release: assert property (
		take_idle && (i_wr_byte == lpd_pkg::LPD_CMD_NINV_OFF) |=> !ninv_on_ff)
		else $error("84h did not release inversion");

	chk_pump_load: assert property (
		take && (state_ff == ST_PUMP_ARG) |=> o_pump_div == $past(i_wr_byte[3:0]))
		else $error("divider value byte not loaded");

	chk_arg_swallow: assert property (
		take && (state_ff != ST_IDLE)
		|=> $stable(part_mode_ff) && $stable(o_osc_slow) && $stable(o_test_mode))
		else $error("value byte decoded as an opcode");

	chk_test_enter: assert property (
		take_idle && (i_wr_byte >= lpd_pkg::LPD_CMD_TEST_FIRST) |=> o_test_mode)
		else $error("test opcode did not enter test mode");

	cov_partial: cover property (take_idle && (i_wr_byte == lpd_pkg::LPD_CMD_MODE_PART));
	cov_start:   cover property (take && (state_ff == ST_START_ARG));
	cov_ninv:    cover property (o_drive_cfg.ninv_on);
	cov_pump:    cover property (take && (state_ff == ST_PUMP_ARG));
	cov_test:    cover property (o_test_mode ##1 !o_test_mode);

endmodule : lpd_cmd_decoder

//--- testbench/lpd_host_model.sv
`timescale 1ns/10ps
// Host processor side of the byte port: one byte per call, back to back when called in a row.
module lpd_host_model (
	// Clock.
	input  wire logic       i_clk,
	// Byte port towards the decoder.
	output logic            o_wr_strobe,
	output logic            o_register_select,
	output logic [7:0]      o_wr_byte
);
	// The port starts idle.
	initial begin
		o_wr_strobe = 1'b0;
		o_register_select = 1'b0;
		o_wr_byte = 8'h00;
	end

	// Presents one byte at a falling edge for the following rising edge.
	// Callers send the value byte of a paired opcode as the next command-phase write; display data writes may come between.
	task automatic wr(input logic [7:0] b, input logic rs);
		@(negedge i_clk);
		o_wr_strobe <= 1'b1;
		o_register_select <= rs;
		o_wr_byte <= b;
	endtask : wr

	// Ends a burst; the stale byte is inverted so that nothing may rely on it.
	task automatic idle();
		@(negedge i_clk);
		o_wr_strobe <= 1'b0;
		o_wr_byte <= ~o_wr_byte;
	endtask : idle
endmodule : lpd_host_model

//--- testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
	localparam int T  = 50;
	localparam int DW = $bits(lpd_pkg::lpd_drive_t);
	typedef struct {int due; int kind; logic [64:0] v;} lpd_note_t;
	logic                          i_clk, i_sys_rst, i_clk_en, i_normal_bias;
	logic                          i_duty_option_pin_hi, i_duty_option_pin_lo;
	logic                          wr_strobe, register_select, o_osc_slow, o_test_mode;
	logic [7:0]                    wr_byte, rb;
	logic [lpd_pkg::LPD_DIV_W-1:0] o_pump_div;
	lpd_pkg::lpd_drive_t           o_drive_cfg;
	logic [64:0]                   o_com_active;
	int                            num_errors, n_tests, cyc;
	lpd_note_t                     q[$];
	logic [31:0]                   rng;
	logic                          m_part, m_osc, m_test, m_ninv;
	logic [2:0]                    m_duty, m_bias;
	logic [5:0]                    m_start;
	logic [4:0]                    m_nval;
	logic [3:0]                    m_div;
	logic [7:0]                    m_pend;

	// Device under test and the host that writes to it.
	lpd_cmd_decoder #(.NUM_COM(65)) i_lpd_cmd_decoder (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
		.i_wr_strobe(wr_strobe), .i_register_select(register_select), .i_wr_byte(wr_byte),
		.i_duty_option_pin_hi(i_duty_option_pin_hi), .i_duty_option_pin_lo(i_duty_option_pin_lo),
		.i_normal_bias(i_normal_bias), .o_osc_slow(o_osc_slow), .o_pump_div(o_pump_div),
		.o_test_mode(o_test_mode), .o_drive_cfg(o_drive_cfg), .o_com_active(o_com_active));
	lpd_host_model i_lpd_host_model (.i_clk(i_clk), .o_wr_strobe(wr_strobe),
		.o_register_select(register_select), .o_wr_byte(wr_byte));

	// Clock and a count of rising edges used to time the expectations.
	initial i_clk = 1'b0;
	always #(T/2) i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;

	// Xorshift generator for value bytes and the normal bias input.
	function automatic logic [7:0] r8();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction : r8

	function automatic logic [6:0] nlines(input logic [2:0] c);
		case (c)
			3'h0: return 7'h08;
			3'h1: return 7'h10;
			3'h2: return 7'h20;
			3'h3: return 7'h30;
			default: return 7'h40;
		endcase
	endfunction : nlines

	// Expected drive settings: clamp to the strap maximum, zero start past it, gate inversion.
	function automatic lpd_pkg::lpd_drive_t edrv();
		lpd_pkg::lpd_drive_t e;
		logic [2:0] mx;
		mx = (!i_duty_option_pin_hi) ? (i_duty_option_pin_lo ? 3'h3 : 3'h2) : 3'h4;
		e = '0;
		e.partial = m_part;
		e.normal_bias = i_normal_bias;
		e.ninv_lines = m_nval;
		e.duty_code = mx;
		if (m_part) begin
			e.duty_code = (m_duty > mx) ? mx : m_duty;
			e.bias_code = m_bias;
			e.start_line = ({1'b0, m_start} > nlines(mx)) ? 6'h00 : m_start;
		end
		e.ninv_on = m_ninv && !(m_part && e.duty_code <= 3'h1);
		return e;
	endfunction : edrv

	// Expected select mask: the scanned window plus the indicator common.
	function automatic logic [64:0] ecom(input lpd_pkg::lpd_drive_t e);
		logic [64:0] m;
		m = '0;
		m[64] = 1'b1;
		for (int i = 0; i < 64; i++) begin
			m[i] = (i >= int'(e.start_line)) && (i < int'(e.start_line) + int'(nlines(e.duty_code)));
		end
		return m;
	endfunction : ecom

	// Reference state after reset.
	task automatic mreset();
		{m_part, m_osc, m_test, m_ninv} = 4'h0;
		m_duty = 3'h4;
		m_bias = 3'h5;
		m_start = 6'h00;
		m_nval = 5'h00;
		m_div = 4'h3;
		m_pend = 8'h00;
	endtask : mreset

	// Reference decoding of one command byte.
	task automatic upd(input logic [7:0] b);
		logic [7:0] p;
		p = m_pend;
		m_pend = 8'h00;
		if (p == 8'hD3) m_start = b[5:0];
		else if (p == 8'hE6) m_div = b[3:0];
		else if (p == 8'h85) begin
			m_ninv = 1'b1;
			m_nval = b[4:0];
		end else case (b) inside
			8'hE4: m_osc = 1'b0;
			8'hE5: m_osc = 1'b1;
			8'h82: m_part = 1'b0;
			8'h83: m_part = 1'b1;
			8'h84: m_ninv = 1'b0;
			8'hE2: m_test = 1'b0;
			8'h85, 8'hD3, 8'hE6: m_pend = b;
			[8'h30:8'h34]: begin
				m_duty = b[2:0];
				m_bias = (b[2:0] == 3'h4) ? 3'h5 : b[2:0];
			end
			[8'h38:8'h3D]: m_bias = b[2:0];
			[8'hF0:8'hFF]: m_test = 1'b1;
			default: ;
		endcase
	endtask : upd

	// Notes the expected outputs, dc and dd rising edges from now.
	task automatic expect_at(input int dc, input int dd);
		q.push_back('{cyc + dc, 0, 65'({m_osc, m_div, m_test})});
		q.push_back('{cyc + dd, 1, 65'(edrv())});
		q.push_back('{cyc + dd, 2, ecom(edrv())});
	endtask : expect_at

	task automatic cmd(input logic [7:0] b, input logic rs = 1'b0);
		i_lpd_host_model.wr(b, rs);
		if (!rs) upd(b);
		expect_at(1, 2);
	endtask : cmd

	task automatic straps(input logic hi, input logic lo);
		i_lpd_host_model.idle();
		// Let the last command's drive settings land on the old straps first.
		@(negedge i_clk);
		rb = r8();
		i_duty_option_pin_hi = hi;
		i_duty_option_pin_lo = lo;
		i_normal_bias = rb[0];
		expect_at(0, 1);
	endtask : straps

	task automatic cmp_ctl(input logic [5:0] e, input logic [5:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t ctl exp %h got %h", $time, e, g);
		end
	endtask : cmp_ctl

	task automatic cmp_drv(input lpd_pkg::lpd_drive_t e, input lpd_pkg::lpd_drive_t g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t drive exp %h got %h", $time, e, g);
		end
	endtask : cmp_drv

	task automatic cmp_com(input logic [64:0] e, input logic [64:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t mask exp %h got %h", $time, e, g);
		end
	endtask : cmp_com

	// Takes each note off the queue once its cycle has come and compares it.
	always @(negedge i_clk) begin : watch
		lpd_note_t n;
		while (q.size() > 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			case (n.kind)
				0: cmp_ctl(n.v[5:0], {o_osc_slow, o_pump_div, o_test_mode});
				1: cmp_drv(lpd_pkg::lpd_drive_t'(n.v[DW-1:0]), o_drive_cfg);
				default: cmp_com(n.v, o_com_active);
			endcase
		end
	end

	task automatic tdone(input string name);
		i_lpd_host_model.idle();
		repeat (3) @(negedge i_clk);
		$display("test %s done, %0d checks, %0d mismatches", name, n_tests, num_errors);
	endtask : tdone

	task automatic do_reset();
		i_sys_rst = 1'b1;
		mreset();
		repeat (2) @(negedge i_clk);
		i_sys_rst = 1'b0;
		expect_at(1, 1);
	endtask : do_reset

	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	// Cuts a hang short.
	initial begin
		#(T * 4000);
		num_errors++;
		end_sim();
	end

	// Main sequence of scenarios.
	initial begin
		{num_errors, n_tests} = '0;
		rng = 32'h0000_005A;
		{i_clk_en, i_duty_option_pin_hi, i_duty_option_pin_lo, i_normal_bias} = 4'b1100;
		do_reset();
		tdone("reset");
		cmd(8'hE5);
		cmd(8'hE4);
		tdone("oscillator");
		cmd(8'h83);
		for (int b = 8'h30; b <= 8'h37; b++) cmd(8'(b));
		for (int b = 8'h38; b <= 8'h3F; b++) cmd(8'(b));
		cmd(8'h82);
		cmd(8'h31);
		cmd(8'h83);
		tdone("modes");
		straps(1'b0, 1'b0);
		cmd(8'h34);
		straps(1'b0, 1'b1);
		cmd(8'h34);
		straps(1'b0, 1'b0);
		tdone("clamp");
		rb = r8();
		cmd(8'hD3);
		cmd({rb[7:6], 6'h21});
		cmd(8'hD3);
		cmd(8'h20);
		cmd(8'hD3);
		cmd({rb[5:4], 6'h14});
		tdone("start line");
		cmd(8'h85);
		cmd(r8());
		cmd(8'h30);
		cmd(8'h31);
		cmd(8'h32);
		cmd(8'h84);
		tdone("inversion");
		for (int i = 0; i < 16; i++) begin
			rb = r8();
			cmd(8'hE6);
			cmd({rb[7:4], 4'(i)});
		end
		tdone("pump divider");
		cmd(8'hD3);
		cmd(8'hA5, 1'b1);
		cmd(8'hE5);
		cmd(8'h85);
		cmd(8'h84);
		cmd(8'hE6);
		cmd(8'hF0);
		tdone("paired values");
		cmd(8'hF0);
		cmd(8'hE5);
		cmd(8'hE2);
		cmd(8'hFF);
		tdone("test mode");
		do_reset();
		tdone("second reset");
		i_clk_en = 1'b0;
		i_lpd_host_model.wr(8'hE5, 1'b0);
		expect_at(1, 2);
		i_lpd_host_model.idle();
		@(negedge i_clk);
		i_clk_en = 1'b1;
		tdone("clock enable");
		end_sim();
	end
endmodule : testbench
